// file: core/serial_flash_pkg.sv
// constants and types for the paged serial flash front end
// assumes: compiled before the core module that imports it
package serial_flash_pkg;

   // array organization
   localparam int ADDR_W = 19;
   localparam int MEM_BYTES = 524288;
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_IDX_W = 8;
   localparam int SUBSECTOR_PAGES = 16;
   localparam int SECTOR_PAGES = 256;
   localparam int SECTOR_W = 3;
   localparam logic [SECTOR_W-1:0] TOP_SECTOR = 3'h7;
   localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'(PAGE_BYTES - 1);
   localparam logic [ADDR_W-1:0] SUBSECTOR_MASK = ADDR_W'(PAGE_BYTES * SUBSECTOR_PAGES - 1);
   localparam logic [ADDR_W-1:0] SECTOR_MASK = ADDR_W'(PAGE_BYTES * SECTOR_PAGES - 1);
   localparam logic [ADDR_W-1:0] ARRAY_MASK = ADDR_W'(MEM_BYTES - 1);
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // byte positions inside a frame
   localparam logic [2:0] BYTE_OPCODE = 3'h0;
   localparam logic [2:0] BYTE_ONE = 3'h1;
   localparam logic [2:0] BYTE_TWO = 3'h2;
   localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
   localparam logic [2:0] BYTE_DATA = 3'h4;

   // instruction codes
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_UPDATE_CMD = 8'h01;
   localparam logic [7:0] DATA_READ_CMD = 8'h03;
   localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0A;
   localparam logic [7:0] PAGE_FILL_CMD = 8'h02;
   localparam logic [7:0] PAGE_CLEAR_CMD = 8'hDB;
   localparam logic [7:0] SUBSECTOR_CLEAR_CMD = 8'h20;
   localparam logic [7:0] SECTOR_CLEAR_CMD = 8'hD8;
   localparam logic [7:0] ARRAY_CLEAR_CMD = 8'hC7;

   // status byte fields
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP = 2;
   localparam int SR_LOCKOUT = 7;

   // register port
   localparam int REG_ADDR_W = 4;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [REG_ADDR_W-1:0] REG_CONTROL = 4'h4;
   localparam logic [REG_ADDR_W-1:0] REG_PEEK_ADDR = 4'h8;
   localparam logic [REG_ADDR_W-1:0] REG_PEEK_DATA = 4'hC;
   localparam int RS_STANDBY = 8;
   localparam int RS_RESET_MODE = 9;
   localparam int RS_FRAME = 10;
   localparam int CTRL_FREEZE = 0;

   // pin synchroniser reset image: clock low, select high, reset high, protect high
   localparam int PIN_COUNT = 5;
   localparam logic [PIN_COUNT-1:0] SYNC_RESET = 5'h0B;

   typedef enum {CYC_IDLE, CYC_LOAD, CYC_ERASE, CYC_PROGRAM} cycle_state_e;

   typedef struct packed {
      logic spi_clk;
      logic select_n;
      logic serial_in;
      logic hw_reset_n;
      logic protect_n;
   } pin_bundle_s;

endpackage

// file: core/serial_paged_flash_interface.sv
// serial front end, page buffer, erase/program engine and array
// assumes: serial pins are asynchronous and at least 8x slower than clock
`timescale 1ns/10ps

// What this block does
// [RULE1] drive each output bit after a falling serial clock edge
// [RULE2] sample command, address and data bits on rising serial clock edges
// [RULE3] output floats whenever select is high
// [RULE4] standby only when deselected and no internal cycle runs
// [RULE5] frames count only when opened by a select falling edge
// [RULE6] hardware reset low holds reset mode with output floating
// [RULE7] hardware reset high lets frames run normally
// [RULE8] reset during a write, program or erase cycle aborts it
// [RULE9] page write and program take 1 to 256 data bytes
// [RULE10] page write loads untouched bytes, erases the page, then programs it
// [RULE11] array is 8 sectors of 16 subsectors each
// [RULE12] sector is 256 pages, subsector 16 pages, page 256 bytes
// [RULE13] byte wide array of four megabits
// [RULE14] erase by page, subsector, sector or whole array
// [RULE15] protection works on 64 Kbyte sectors
// [RULE16] newer variant has 4 Kbyte subsector erase and whole array erase
// [RULE17] newer variant writes only three protect bits and the lockout bit
// [RULE18] protect pin with lockout freezes the protect bits; 001 guards top sector
// [RULE19] protect pin is top lock or write protect by parameter
// [RULE20] works with clock idling low or high
// [RULE21] write frame is opcode, three address bytes, data; cycle starts at deselect
// [RULE22] busy flag shows while an internal cycle runs
// [RULE23] shifter and bit counter restart on every deselect
// [RULE24] data past the page end wraps inside the same page
module serial_paged_flash_interface
   import serial_flash_pkg::*;
#(
   parameter bit NEW_VARIANT = 1'b1
)
(
   // system clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial pins
   input wire logic spi_clk,
   input wire logic select_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_en,
   input wire logic hw_reset_n,
   input wire logic protect_n,
   // device state
   output logic busy_flag,
   output logic standby,
   // register port
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata
);

   logic [PIN_COUNT-1:0] pins_raw, sync1_reg, sync2_reg;
   pin_bundle_s pins;
   logic sclk_prev_reg, sel_prev_reg;
   logic sclk_rise, sclk_fall, sel_fall, sel_rise, dev_reset;
   logic frame_live_reg, frame_end, frame_ok, busy;
   logic [7:0] shift_reg, rx_byte, opcode_reg, tx_byte_reg;
   logic [7:0] status_byte, status_new_reg;
   logic [2:0] bit_cnt_reg, byte_cnt_reg;
   logic byte_done, data_byte_in, status_write;
   logic [23:0] addr_reg, addr_full;
   logic [ADDR_W-1:0] frame_addr, read_ptr_reg;
   logic out_phase_reg, serial_out_reg, serial_out_en_reg;
   logic [7:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] buf_valid_reg;
   logic [PAGE_IDX_W-1:0] buf_ptr_reg, idx;
   logic [7:0] mem [MEM_BYTES];
   cycle_state_e state_reg, go_state;
   logic [ADDR_W-1:0] ptr_reg, end_reg, go_mask, go_end;
   logic rewrite_reg, wel_reg, lockout_reg, freeze_reg, go, go_rewrite, cmd_ok;
   logic [2:0] bp_reg;
   logic [ADDR_W-1:0] peek_addr_reg;
   logic busy_reg, standby_reg;
   logic [31:0] rdata_reg;

   // sector guard, shared by the engine start and its check
   function automatic logic sector_locked(input logic [SECTOR_W-1:0] sector,
                                          input logic [2:0] bp, input logic pin_n);
      logic hit;
      hit = 1'b0;
      if (!NEW_VARIANT)
         hit = !pin_n && (sector == TOP_SECTOR); // RULE19
      else
      begin
         case (bp) // RULE15 RULE18
            3'h0: hit = 1'b0;
            3'h1: hit = (sector == TOP_SECTOR);
            3'h2: hit = (sector >= 3'h6);
            3'h3: hit = (sector >= 3'h4);
            default: hit = 1'b1;
         endcase
      end
      return hit;
   endfunction

   // two-stage synchroniser on every pin
   assign pins_raw = {spi_clk, select_n, serial_in, hw_reset_n, protect_n};
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sync1_reg <= SYNC_RESET;
         sync2_reg <= SYNC_RESET;
      end
      else
      begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end
   assign pins = pin_bundle_s'(sync2_reg);

   // edge finders; either idle clock level works since both edges are seen
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sclk_prev_reg <= 1'b0;
         sel_prev_reg <= 1'b1;
      end
      else
      begin
         sclk_prev_reg <= pins.spi_clk;
         sel_prev_reg <= pins.select_n;
      end
   end
   assign sclk_rise = pins.spi_clk && !sclk_prev_reg; // RULE2 RULE20
   assign sclk_fall = !pins.spi_clk && sclk_prev_reg; // RULE1 RULE20
   assign sel_fall = !pins.select_n && sel_prev_reg;
   assign sel_rise = pins.select_n && !sel_prev_reg;
   assign dev_reset = !pins.hw_reset_n; // RULE6 RULE7
   assign busy = (state_reg != CYC_IDLE);
   assign frame_end = sel_rise && frame_live_reg;
   assign frame_ok = frame_end && (bit_cnt_reg == 3'h0) && !busy;

   // a frame only counts if its select falling edge was seen
   always_ff @(posedge clock)
   begin
      if (!rst_n || dev_reset)
         frame_live_reg <= 1'b0;
      else if (sel_fall)
         frame_live_reg <= 1'b1; // RULE5 RULE7
      else if (pins.select_n)
         frame_live_reg <= 1'b0;
   end

   // input shifter, msb first
   assign byte_done = sclk_rise && frame_live_reg && (bit_cnt_reg == 3'h7);
   assign rx_byte = {shift_reg[6:0], pins.serial_in};
   always_ff @(posedge clock)
   begin
      if (!rst_n || !frame_live_reg || pins.select_n)
      begin
         shift_reg <= 8'h00; // RULE23
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= BYTE_OPCODE;
      end
      else if (sclk_rise)
      begin
         shift_reg <= rx_byte; // RULE2
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7 && byte_cnt_reg != BYTE_DATA)
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
   end

   // opcode, address and status byte capture
   assign addr_full = {addr_reg[15:0], rx_byte};
   assign frame_addr = addr_reg[ADDR_W-1:0]; // RULE13
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         opcode_reg <= 8'h00;
         addr_reg <= 24'h000000;
         status_new_reg <= 8'h00;
      end
      else if (byte_done)
      begin
         if (byte_cnt_reg == BYTE_OPCODE)
            opcode_reg <= rx_byte;
         else if (byte_cnt_reg != BYTE_DATA)
            addr_reg <= addr_full;
         if (byte_cnt_reg == BYTE_ONE)
            status_new_reg <= rx_byte;
      end
   end

   // status byte image
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[SR_BUSY] = busy; // RULE22
      status_byte[SR_WEL] = wel_reg;
      status_byte[SR_BP +: 3] = bp_reg;
      status_byte[SR_LOCKOUT] = lockout_reg;
   end

   // next outgoing byte; reads of the array are refused while busy
   always_ff @(posedge clock)
   begin
      if (!rst_n || !frame_live_reg)
      begin
         out_phase_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
         read_ptr_reg <= '0;
      end
      else if (byte_done)
      begin
         if (byte_cnt_reg == BYTE_OPCODE && rx_byte == STATUS_READ_CMD)
         begin
            out_phase_reg <= 1'b1;
            tx_byte_reg <= status_byte;
         end
         else if (byte_cnt_reg != BYTE_OPCODE && opcode_reg == STATUS_READ_CMD)
            tx_byte_reg <= status_byte;
         else if (opcode_reg == DATA_READ_CMD && byte_cnt_reg == BYTE_ADDR_LAST && !busy)
         begin
            out_phase_reg <= 1'b1;
            tx_byte_reg <= mem[addr_full[ADDR_W-1:0]];
            read_ptr_reg <= addr_full[ADDR_W-1:0] + 1'b1;
         end
         else if (opcode_reg == DATA_READ_CMD && byte_cnt_reg == BYTE_DATA)
         begin
            tx_byte_reg <= mem[read_ptr_reg];
            read_ptr_reg <= read_ptr_reg + 1'b1;
         end
      end
   end

   // output bit moves only on a falling clock edge
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         serial_out_reg <= 1'b0;
      else if (sclk_fall && out_phase_reg)
         serial_out_reg <= tx_byte_reg[~bit_cnt_reg]; // RULE1
   end

   // output enable drops one cycle after deselect or reset pin
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         serial_out_en_reg <= 1'b0;
      else
         serial_out_en_reg <= out_phase_reg && frame_live_reg && !pins.select_n && !dev_reset; // RULE3 RULE6
   end

   // page buffer data; the engine fills untouched bytes from the array
   assign data_byte_in = byte_done && byte_cnt_reg == BYTE_DATA && !busy &&
                         (opcode_reg == PAGE_REWRITE_CMD || opcode_reg == PAGE_FILL_CMD);
   assign idx = ptr_reg[PAGE_IDX_W-1:0];
   always_ff @(posedge clock)
   begin
      if (state_reg == CYC_LOAD && !buf_valid_reg[idx])
         page_buf[idx] <= mem[ptr_reg]; // RULE10
      else if (data_byte_in)
         page_buf[buf_ptr_reg] <= rx_byte; // RULE9
   end

   // buffer fill marks and load pointer
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         buf_valid_reg <= '0;
         buf_ptr_reg <= '0;
      end
      else if (byte_done && byte_cnt_reg == BYTE_OPCODE && !busy)
         buf_valid_reg <= '0;
      else if (byte_done && byte_cnt_reg == BYTE_ADDR_LAST)
         buf_ptr_reg <= rx_byte;
      else if (data_byte_in)
      begin
         buf_valid_reg[buf_ptr_reg] <= 1'b1;
         buf_ptr_reg <= buf_ptr_reg + 1'b1; // RULE24
      end
   end

   // command decode at deselect
   assign go_end = frame_addr | go_mask;
   always_comb
   begin
      go = 1'b0;
      go_rewrite = 1'b0;
      go_state = CYC_ERASE;
      go_mask = PAGE_MASK; // RULE12
      cmd_ok = frame_ok && wel_reg && !freeze_reg && byte_cnt_reg == BYTE_DATA; // RULE21
      case (opcode_reg)
         PAGE_REWRITE_CMD:
         begin
            go = cmd_ok && (|buf_valid_reg); // RULE9 RULE10
            go_rewrite = 1'b1;
            go_state = CYC_LOAD;
         end
         PAGE_FILL_CMD:
         begin
            go = cmd_ok && (|buf_valid_reg);
            go_state = CYC_PROGRAM;
         end
         PAGE_CLEAR_CMD: go = cmd_ok; // RULE14
         SUBSECTOR_CLEAR_CMD:
         begin
            go = NEW_VARIANT && cmd_ok; // RULE16
            go_mask = SUBSECTOR_MASK; // RULE11
         end
         SECTOR_CLEAR_CMD:
         begin
            go = cmd_ok;
            go_mask = SECTOR_MASK; // RULE11
         end
         ARRAY_CLEAR_CMD:
         begin
            go = NEW_VARIANT && frame_ok && wel_reg && !freeze_reg &&
                 byte_cnt_reg == BYTE_ONE; // RULE16
            go_mask = ARRAY_MASK;
         end
         default: go = 1'b0;
      endcase
      if (sector_locked(go_end[ADDR_W-1 -: SECTOR_W], bp_reg, pins.protect_n))
         go = 1'b0; // RULE15
   end

   // erase/program engine, one byte per clock; reset pin aborts it
   always_ff @(posedge clock)
   begin
      if (!rst_n || dev_reset)
      begin
         state_reg <= CYC_IDLE; // RULE8
         ptr_reg <= '0;
         end_reg <= '0;
         rewrite_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            CYC_IDLE:
               if (go)
               begin
                  state_reg <= go_state;
                  ptr_reg <= frame_addr & ~go_mask;
                  end_reg <= go_end;
                  rewrite_reg <= go_rewrite;
               end
            CYC_LOAD:
               if (ptr_reg == end_reg)
               begin
                  state_reg <= CYC_ERASE;
                  ptr_reg <= end_reg & ~PAGE_MASK;
               end
               else
                  ptr_reg <= ptr_reg + 1'b1;
            CYC_ERASE:
               if (ptr_reg == end_reg)
               begin
                  state_reg <= rewrite_reg ? CYC_PROGRAM : CYC_IDLE; // RULE10
                  ptr_reg <= end_reg & ~PAGE_MASK;
               end
               else
                  ptr_reg <= ptr_reg + 1'b1;
            CYC_PROGRAM:
               if (ptr_reg == end_reg)
                  state_reg <= CYC_IDLE;
               else
                  ptr_reg <= ptr_reg + 1'b1;
            default: state_reg <= CYC_IDLE;
         endcase
      end
   end

   // array writes; a fill only clears bits, a rewrite stores the buffer
   always_ff @(posedge clock)
   begin
      if (rst_n && !dev_reset)
      begin
         if (state_reg == CYC_ERASE)
            mem[ptr_reg] <= ERASED_BYTE; // RULE14
         else if (state_reg == CYC_PROGRAM && (rewrite_reg || buf_valid_reg[idx]))
            mem[ptr_reg] <= rewrite_reg ? page_buf[idx] : (mem[ptr_reg] & page_buf[idx]);
      end
   end

   // write latch and the writable status bits
   assign status_write = NEW_VARIANT && frame_ok && wel_reg && byte_cnt_reg == BYTE_TWO &&
                         opcode_reg == STATUS_UPDATE_CMD &&
                         !(lockout_reg && !pins.protect_n); // RULE17 RULE18
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wel_reg <= 1'b0;
         bp_reg <= 3'h0;
         lockout_reg <= 1'b0;
      end
      else if (dev_reset || go)
         wel_reg <= 1'b0;
      else if (frame_ok && byte_cnt_reg == BYTE_ONE && opcode_reg == WRITE_ENABLE_CMD)
         wel_reg <= 1'b1;
      else if (frame_ok && byte_cnt_reg == BYTE_ONE && opcode_reg == WRITE_DISABLE_CMD)
         wel_reg <= 1'b0;
      else if (status_write)
      begin
         bp_reg <= status_new_reg[SR_BP +: 3]; // RULE17
         lockout_reg <= status_new_reg[SR_LOCKOUT];
         wel_reg <= 1'b0;
      end
   end

   // registered pin-side state outputs
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         busy_reg <= 1'b0;
         standby_reg <= 1'b1;
      end
      else
      begin
         busy_reg <= busy; // RULE22
         standby_reg <= pins.select_n && !busy; // RULE4
      end
   end

   // software-written controls; freeze refuses new internal cycles
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         freeze_reg <= 1'b0;
         peek_addr_reg <= '0;
      end
      else if (reg_write && reg_addr == REG_CONTROL)
         freeze_reg <= reg_wdata[CTRL_FREEZE];
      else if (reg_write && reg_addr == REG_PEEK_ADDR)
         peek_addr_reg <= reg_wdata[ADDR_W-1:0];
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clock)
   begin
      if (!rst_n || !reg_read)
         rdata_reg <= 32'h0000_0000;
      else
      begin
         rdata_reg <= 32'h0000_0000;
         case (reg_addr)
            REG_STATUS:
            begin
               rdata_reg[7:0] <= status_byte;
               rdata_reg[RS_STANDBY] <= standby_reg;
               rdata_reg[RS_RESET_MODE] <= dev_reset;
               rdata_reg[RS_FRAME] <= frame_live_reg;
            end
            REG_CONTROL: rdata_reg[CTRL_FREEZE] <= freeze_reg;
            REG_PEEK_ADDR: rdata_reg[ADDR_W-1:0] <= peek_addr_reg;
            REG_PEEK_DATA: rdata_reg[7:0] <= mem[peek_addr_reg];
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign serial_out = serial_out_reg;
   assign serial_out_en = serial_out_en_reg;
   assign busy_flag = busy_reg;
   assign standby = standby_reg;
   assign reg_rdata = rdata_reg;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_cycle_begin;
      (state_reg == CYC_IDLE) ##1 (state_reg != CYC_IDLE);
   endsequence
   sequence s_rewrite_erase_done;
      (state_reg == CYC_ERASE && rewrite_reg) ##1 (state_reg != CYC_ERASE);
   endsequence

   a_out_on_fall: // RULE1
      assert property ($changed(serial_out_reg) |-> $past(sclk_fall))
      else $error("serial out moved without a clock fall");
   a_in_on_rise: // RULE2
      assert property ((bit_cnt_reg != 3'h0 && $changed(bit_cnt_reg)) |-> $past(sclk_rise))
      else $error("bit counter moved without a clock rise");
   a_desel_float: // RULE3
      assert property (pins.select_n |=> !serial_out_en_reg)
      else $error("output driven while deselected");
   a_standby_idle: // RULE4
      assert property (standby_reg |-> $past(pins.select_n && !busy))
      else $error("standby while selected or busy");
   a_start_frame: // RULE5 RULE21
      assert property (s_cycle_begin |-> $past(frame_end))
      else $error("internal cycle began outside a frame end");
   a_reset_float: // RULE6 RULE8
      assert property (dev_reset |=> (!serial_out_en_reg && state_reg == CYC_IDLE))
      else $error("reset pin did not float output and abort");
   a_busy_shown: // RULE22
      assert property (s_cycle_begin |=> busy_flag)
      else $error("busy flag missing after cycle start");
   a_rewrite_order: // RULE10
      assert property (s_rewrite_erase_done |-> (state_reg == CYC_PROGRAM || $past(dev_reset)))
      else $error("page rewrite erase not followed by program");
   a_status_write: // RULE17
      assert property ($changed(bp_reg) |-> $past(status_write))
      else $error("protect bits changed without a status update");
   a_lock_refuse: // RULE15
      assert property (s_cycle_begin |->
                       !sector_locked(end_reg[ADDR_W-1 -: SECTOR_W], bp_reg, $past(pins.protect_n)))
      else $error("cycle started in a protected sector");
   a_page_wrap: // RULE24
      assert property ((data_byte_in && buf_ptr_reg == 8'hFF) |=> buf_ptr_reg == 8'h00)
      else $error("page pointer left the page");

endmodule

// file: test/spi_master_model.sv
// master model driving the serial pins of the flash front end
// assumes: clock is the 20 MHz system clock, 4 clocks per link half period
`timescale 1ns/10ps
module spi_master_model
(
   // timing
   input wire logic clock,
   // serial pins
   output logic spi_clk,
   output logic select_n,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en
);
   bit cpol = 1'b0;
   bit saw_en = 1'b0;

   // idle pins at time zero; select high keeps the device out of a frame
   initial
   begin
      spi_clk = 1'b0;
      select_n = 1'b1;
      serial_in = 1'b0;
   end

   // one byte msb first; data changes after a fall, device samples on the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         if (cpol)
            spi_clk <= 1'b0;
         serial_in <= tx[i];
         repeat (4) @(posedge clock);
         spi_clk <= 1'b1;
         repeat (4) @(posedge clock);
         rx[i] = serial_out;
         saw_en |= serial_out_en;
         if (!cpol)
            spi_clk <= 1'b0;
      end
   endtask

   // whole frame; clock idles at the chosen level outside it
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx);
      spi_clk <= cpol;
      @(posedge clock);
      select_n <= 1'b0;
      repeat (4) @(posedge clock);
      foreach (tx[i])
         xfer(tx[i], rx);
      repeat (2) @(posedge clock);
      select_n <= 1'b1;
      serial_in <= ~serial_in; // released line must not look held
      repeat (6) @(posedge clock);
   endtask
endmodule

// file: test/serial_paged_flash_interface_bench.sv
// bench for the paged serial flash front end
// assumes: package and core compiled first, master model beside it
`timescale 1ns/10ps
module serial_paged_flash_interface_bench
   import serial_flash_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic hw_reset_n = 1'b1;
   logic protect_n = 1'b1;
   logic spi_clk, select_n, serial_in, serial_out, serial_out_en, busy_flag, standby;
   logic [REG_ADDR_W-1:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] exp_q[$];
   logic [31:0] mask_q[$];
   logic rd_q = 1'b0;
   int miscompares = 0;
   int n_compared = 0;

   always #25 clock = ~clock;

   spi_master_model m (.clock(clock), .spi_clk(spi_clk), .select_n(select_n),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));

   serial_paged_flash_interface dut (.clock(clock), .rst_n(rst_n), .spi_clk(spi_clk),
      .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .hw_reset_n(hw_reset_n), .protect_n(protect_n),
      .busy_flag(busy_flag), .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      n_compared++;
      if ((got & mask) !== (exp & mask))
      begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      repeat (3) @(posedge clock);
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   // the note goes on the queue; the watcher compares when data stand
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k);
      reg_addr <= a;
      reg_read <= 1'b1;
      exp_q.push_back(e);
      mask_q.push_back(k);
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wait_busy(input logic lvl, input int lim);
      for (int i = 0; i < lim && busy_flag !== lvl; i++)
         @(posedge clock);
      check(32'(busy_flag), 32'(lvl), 32'h1);
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge clock)
   begin
      if (rd_q)
         check(reg_rdata, exp_q.pop_front(), mask_q.pop_front());
      rd_q <= reg_read;
   end

   // a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clock);
      miscompares++;
      print_verdict();
   end

   initial
   begin
      logic [7:0] rx, d0, d1;
      logic [10:0] pg;
      void'($urandom(32'ha95d7230));
      repeat (2) @(posedge clock); // synchronisers take their reset image
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      check(32'(standby), 32'h1, 32'h1);
      check(32'(serial_out_en), 32'h0, 32'h1);
      reg_rd(REG_STATUS, 32'h100, 32'h7E3);
      reg_rd(4'h2, 32'h0, 32'hFFFFFFFF);
      reg_wr(REG_CONTROL, 32'h1);
      reg_rd(REG_CONTROL, 32'h1, 32'h1);
      reg_wr(REG_CONTROL, 32'h0);
      // write latch read back with the clock idling low, then high
      for (int p = 0; p < 2; p++)
      begin
         m.cpol = p[0];
         m.frame('{WRITE_ENABLE_CMD}, rx);
         m.frame('{STATUS_READ_CMD, 8'h00}, rx);
         check(32'(rx), 32'h2, 32'h3);
         check(32'(serial_out_en), 32'h0, 32'h1);
      end
      // rewrite two bytes across the page end; the second must wrap
      pg = 11'($urandom) & 11'h3FF;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      m.cpol = 1'b0;
      m.frame('{WRITE_ENABLE_CMD}, rx);
      m.frame('{PAGE_REWRITE_CMD, {5'h0, pg[10:8]}, pg[7:0], 8'hFF, d0, d1}, rx);
      wait_busy(1'b1, 20);
      check(32'(standby), 32'h0, 32'h1);
      wait_busy(1'b0, 1000);
      reg_wr(REG_PEEK_ADDR, {13'h0, pg, 8'hFF});
      reg_rd(REG_PEEK_DATA, 32'(d0), 32'hFF);
      reg_wr(REG_PEEK_ADDR, {13'h0, pg, 8'h00});
      reg_rd(REG_PEEK_DATA, 32'(d1), 32'hFF);
      m.frame('{DATA_READ_CMD, {5'h0, pg[10:8]}, pg[7:0], 8'h00, 8'h00}, rx);
      check(32'(rx), 32'(d1), 32'hFF);
      // protect bits set by a status update; top sector and frozen clears refused
      m.frame('{WRITE_ENABLE_CMD}, rx);
      m.frame('{STATUS_UPDATE_CMD, 8'h04}, rx);
      m.frame('{WRITE_ENABLE_CMD}, rx);
      m.frame('{PAGE_CLEAR_CMD, 8'h07, 8'h00, 8'h00}, rx);
      check(32'(busy_flag), 32'h0, 32'h1);
      reg_wr(REG_CONTROL, 32'h1);
      m.frame('{PAGE_CLEAR_CMD, 8'h00, 8'h00, 8'h00}, rx);
      check(32'(busy_flag), 32'h0, 32'h1);
      reg_wr(REG_CONTROL, 32'h0);
      m.frame('{STATUS_READ_CMD, 8'h00}, rx);
      check(32'(rx), 32'h06, 32'hFF);
      // pin reset keeps the output floating through a whole frame
      hw_reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      reg_rd(REG_STATUS, 32'h200, 32'h200);
      m.saw_en = 1'b0;
      m.frame('{STATUS_READ_CMD, 8'h00}, rx);
      check(32'(m.saw_en), 32'h0, 32'h1);
      hw_reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      m.frame('{STATUS_READ_CMD, 8'h00}, rx);
      check(32'(m.saw_en), 32'h1, 32'h1);
      check(32'(rx), 32'h04, 32'hFF);
      print_verdict();
   end
endmodule
